// ### aetu_pkg.sv
// Package of constants and types for the ADC error and threshold unit.
package aetu_pkg;
    // ==========================================================
    // Register map (word addresses, one 32-bit word each)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_UPPER = 4'h1;
    localparam logic [3:0] ADDR_LOWER = 4'h2;
    localparam logic [3:0] ADDR_SETPT = 4'h3;
    localparam logic [3:0] ADDR_MODE = 4'h4;
    localparam logic [3:0] ADDR_ERROR = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h8;
    localparam logic [3:0] ADDR_PREV = 4'h9;
    localparam logic [3:0] ADDR_FILT = 4'hA;
    // ==========================================================
    // Field layout of the threshold control register
    localparam int CTRL_W = 8;
    localparam int TMD_LSB = 0;
    localparam int SOI_BIT = 3;
    localparam int CALC_LSB = 4;
    localparam logic [7:0] CTRL_WMASK = 8'h7F;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Mode register bits
    localparam int MODE_CONT_BIT = 0;
    localparam int MODE_DSEN_BIT = 1;
    localparam int MODE_PSIS_BIT = 2;
    localparam int MODE_GO_BIT = 3;
    // Status bits
    localparam int ST_THR_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_W = 2;
    // ==========================================================
    // Data widths
    localparam int RES_W = 16;
    localparam int ERR_W = 18;
    // ==========================================================
    // Error calculation codes
    localparam logic [2:0] CALC_CUR_PREV = 3'h0;
    localparam logic [2:0] CALC_CUR_SETPT = 3'h1;
    localparam logic [2:0] CALC_CUR_FILT = 3'h2;
    localparam logic [2:0] CALC_PREV_FILT = 3'h4;
    localparam logic [2:0] CALC_FILT_SETPT = 3'h5;
    // Threshold modes
    localparam logic [2:0] TMD_OFF = 3'h0;
    localparam logic [2:0] TMD_BELOW_LO = 3'h1;
    localparam logic [2:0] TMD_GE_LO = 3'h2;
    localparam logic [2:0] TMD_INSIDE = 3'h3;
    localparam logic [2:0] TMD_OUTSIDE = 3'h4;
    localparam logic [2:0] TMD_LE_UP = 3'h5;
    localparam logic [2:0] TMD_ABOVE_UP = 3'h6;
    localparam logic [2:0] TMD_ALWAYS = 3'h7;
    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRE1,
        ST_CONV1,
        ST_PRE2,
        ST_CONV2,
        ST_CALC,
        ST_CHECK
    } aetu_state_t;
endpackage

// ### aetu_core.sv
// ADC error calculation, threshold check and conversion sequencing unit.
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module aetu_core
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Conversion core
    output logic CONV_START,
    input wire logic CONV_DONE,
    input wire logic [aetu_pkg::RES_W-1:0] CONV_RESULT,
    output logic PRECHARGE_HOLD_HIGH,
    output logic PRECHARGE_SENSOR_HIGH,
    // Interrupt
    output logic IRQ
);
    import aetu_pkg::*;

    // ==========================================================
    // Registers
    logic [CTRL_W-1:0] ctrl_ff;
    logic [RES_W-1:0] upper_ff, lower_ff, setpt_ff, filt_ff, cur_ff, prev_ff, first_ff;
    logic cont_ff, dsen_ff, psis_ff, go_ff;
    logic [ERR_W-1:0] err_ff;
    logic [ST_W-1:0] status_ff, irq_en_ff;
    logic [31:0] rdata_ff;
    logic rvalid_ff;
    aetu_state_t state_ff, nxt_state;

    // ==========================================================
    // Bus decode
    function automatic logic addr_is(input logic [3:0] a, input logic [3:0] reg_a);
        addr_is = a == reg_a;
    endfunction

    // The bus address is the word index, so every register is reachable.
    wire logic [3:0] word_addr = AVS_ADDRESS;
    wire logic rd_req = AVS_READ && !rvalid_ff;
    wire logic wr_ctrl = AVS_WRITE && addr_is(word_addr, ADDR_CTRL);
    wire logic wr_mode = AVS_WRITE && addr_is(word_addr, ADDR_MODE);
    wire logic wr_clr = AVS_WRITE && addr_is(word_addr, ADDR_IRQ_CLR);
    wire logic wr_upper = AVS_WRITE && addr_is(word_addr, ADDR_UPPER);
    wire logic wr_lower = AVS_WRITE && addr_is(word_addr, ADDR_LOWER);
    wire logic wr_setpt = AVS_WRITE && addr_is(word_addr, ADDR_SETPT);
    wire logic wr_filt = AVS_WRITE && addr_is(word_addr, ADDR_FILT);
    wire logic wr_irq_en = AVS_WRITE && addr_is(word_addr, ADDR_IRQ_EN);
    // Reads take one wait cycle; writes complete at once.
    assign AVS_WAITREQUEST = AVS_READ && !rvalid_ff;
    assign AVS_READDATA = rdata_ff;

    function automatic logic [ERR_W-1:0] sx(input logic [RES_W-1:0] v);
        sx = {{(ERR_W-RES_W){1'b0}}, v};
    endfunction

    // ==========================================================
    // Error calculation
    wire logic [2:0] calc = ctrl_ff[CALC_LSB +: 3];
    wire logic [2:0] tmd = ctrl_ff[TMD_LSB +: 3];
    wire logic [ERR_W-1:0] pair_diff = psis_ff ? sx(first_ff) - sx(cur_ff)
                                              : sx(cur_ff) - sx(first_ff);
    wire logic [ERR_W-1:0] cur_term = dsen_ff ? pair_diff : sx(cur_ff);
    wire logic [ERR_W-1:0] d_prev = dsen_ff ? pair_diff : sx(cur_ff) - sx(prev_ff);
    wire logic calc_ok = calc == CALC_CUR_PREV || calc == CALC_CUR_SETPT ||
                         calc == CALC_CUR_FILT || calc == CALC_PREV_FILT ||
                         calc == CALC_FILT_SETPT;
    logic [ERR_W-1:0] err_calc;
    always_comb
    begin
        case (calc)
            CALC_CUR_PREV: err_calc = d_prev;
            CALC_CUR_SETPT: err_calc = cur_term - sx(setpt_ff);
            CALC_CUR_FILT: err_calc = cur_term - sx(filt_ff);
            CALC_PREV_FILT: err_calc = sx(prev_ff) - sx(filt_ff);
            CALC_FILT_SETPT: err_calc = sx(filt_ff) - sx(setpt_ff);
            default: err_calc = err_ff;
        endcase
    end

    // ==========================================================
    // Threshold comparison (signed)
    wire logic signed [ERR_W-1:0] e_s = err_ff;
    wire logic signed [ERR_W-1:0] up_s = sx(upper_ff);
    wire logic signed [ERR_W-1:0] lo_s = sx(lower_ff);
    logic thr_hit;
    always_comb
    begin
        case (tmd)
            TMD_ALWAYS: thr_hit = 1'b1;
            TMD_ABOVE_UP: thr_hit = e_s > up_s;
            TMD_LE_UP: thr_hit = e_s <= up_s;
            TMD_OUTSIDE: thr_hit = e_s < lo_s || e_s > up_s;
            TMD_INSIDE: thr_hit = e_s > lo_s && e_s < up_s;
            TMD_GE_LO: thr_hit = e_s >= lo_s;
            TMD_BELOW_LO: thr_hit = e_s < lo_s;
            default: thr_hit = 1'b0;
        endcase
    end

    // ==========================================================
    // Sequencer
    wire logic check = state_ff == ST_CHECK;
    wire logic thr_evt = check && thr_hit && calc_ok;
    wire logic stop_hw = thr_evt && cont_ff && ctrl_ff[SOI_BIT];
    wire logic go_now = wr_mode ? AVS_WRITEDATA[MODE_GO_BIT] : go_ff;
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (go_ff) nxt_state = ST_PRE1;
            ST_PRE1: nxt_state = ST_CONV1;
            ST_CONV1: if (CONV_DONE) nxt_state = dsen_ff ? ST_PRE2 : ST_CALC;
            ST_PRE2: nxt_state = ST_CONV2;
            ST_CONV2: if (CONV_DONE) nxt_state = ST_CALC;
            ST_CALC: nxt_state = ST_CHECK;
            ST_CHECK: nxt_state = (cont_ff && go_now && !stop_hw) ? ST_PRE1 : ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end
    assign CONV_START = state_ff == ST_PRE1 || state_ff == ST_PRE2;
    assign PRECHARGE_HOLD_HIGH = state_ff == ST_PRE2 || state_ff == ST_CONV2;
    assign PRECHARGE_SENSOR_HIGH = !PRECHARGE_HOLD_HIGH;
    wire logic conv_end = (state_ff == ST_CONV1 && CONV_DONE && !dsen_ff) ||
                          (state_ff == ST_CONV2 && CONV_DONE);
    wire logic [ST_W-1:0] evt = {check, thr_evt};
    wire logic first_take = state_ff == ST_CONV1 && CONV_DONE && dsen_ff;
    wire logic calc_now = state_ff == ST_CALC;
    assign IRQ = |(status_ff & irq_en_ff);

    // ==========================================================
    // Read mux
    logic [31:0] rd_mux;
    always_comb
    begin
        case (word_addr)
            ADDR_CTRL: rd_mux = {24'h000000, 1'b0, ctrl_ff[6:0]};
            ADDR_UPPER: rd_mux = {16'h0000, upper_ff};
            ADDR_LOWER: rd_mux = {16'h0000, lower_ff};
            ADDR_SETPT: rd_mux = {16'h0000, setpt_ff};
            ADDR_MODE: rd_mux = {28'h0000000, go_ff, psis_ff, dsen_ff, cont_ff};
            ADDR_ERROR: rd_mux = {{(32-ERR_W){err_ff[ERR_W-1]}}, err_ff};
            ADDR_STATUS: rd_mux = {{(32-ST_W){1'b0}}, status_ff};
            ADDR_IRQ_EN: rd_mux = {{(32-ST_W){1'b0}}, irq_en_ff};
            ADDR_PREV: rd_mux = {16'h0000, prev_ff};
            ADDR_FILT: rd_mux = {16'h0000, filt_ff};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // ==========================================================
    // Sequencer state
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            state_ff <= ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // Bus read path
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
        end
        else
        begin
            rvalid_ff <= rd_req;
            if (rd_req)
            begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // ==========================================================
    // Software registers
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            ctrl_ff <= CTRL_RST;
            {upper_ff, lower_ff, setpt_ff, filt_ff} <= '0;
            irq_en_ff <= '0;
        end
        else
        begin
            if (wr_ctrl) ctrl_ff <= AVS_WRITEDATA[CTRL_W-1:0] & CTRL_WMASK;
            if (wr_upper) upper_ff <= AVS_WRITEDATA[RES_W-1:0];
            if (wr_lower) lower_ff <= AVS_WRITEDATA[RES_W-1:0];
            if (wr_setpt) setpt_ff <= AVS_WRITEDATA[RES_W-1:0];
            if (wr_filt) filt_ff <= AVS_WRITEDATA[RES_W-1:0];
            if (wr_irq_en) irq_en_ff <= AVS_WRITEDATA[ST_W-1:0];
        end
    end

    // ==========================================================
    // Mode bits
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            {cont_ff, dsen_ff, psis_ff} <= 3'h0;
        end
        else if (wr_mode)
        begin
            cont_ff <= AVS_WRITEDATA[MODE_CONT_BIT];
            dsen_ff <= AVS_WRITEDATA[MODE_DSEN_BIT];
            psis_ff <= AVS_WRITEDATA[MODE_PSIS_BIT];
        end
    end

    // ==========================================================
    // Conversion go bit
    // The stop-on-threshold clear of go wins over a software write in the same cycle; the single-run clear at the check gives way to it.
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            go_ff <= 1'b0;
        end
        else if (stop_hw)
        begin
            go_ff <= 1'b0;
        end
        else if (check && !cont_ff && !wr_mode)
        begin
            go_ff <= 1'b0;
        end
        else if (wr_mode)
        begin
            go_ff <= AVS_WRITEDATA[MODE_GO_BIT];
        end
    end

    // ==========================================================
    // Conversion samples and error value
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            {cur_ff, prev_ff, first_ff, err_ff} <= '0;
        end
        else
        begin
            if (first_take)
            begin
                first_ff <= CONV_RESULT;
            end
            if (conv_end)
            begin
                prev_ff <= cur_ff;
                cur_ff <= CONV_RESULT;
            end
            if (calc_now)
            begin
                err_ff <= err_calc;
            end
        end
    end

    // ==========================================================
    // Sticky status bits
    generate
        for (genvar i = 0; i < ST_W; i++)
        begin : g_status
            // A new event wins over a clear in the same cycle.
            always_ff @(posedge CLK_SYS)
            begin
                if (RST)
                begin
                    status_ff[i] <= 1'b0;
                end
                else if (evt[i])
                begin
                    status_ff[i] <= 1'b1;
                end
                else if (wr_clr && AVS_WRITEDATA[i])
                begin
                    status_ff[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### aetu_monitor.sv
// Bus and sequencer checks on the ports of the ADC error and threshold unit.
`timescale 1ns/1ps
`default_nettype none
module aetu_chk
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Register bus
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // Conversion core and interrupt
    input wire logic CONV_START,
    input wire logic PRECHARGE_HOLD_HIGH,
    input wire logic PRECHARGE_SENSOR_HIGH,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // ==========================================================
    // Assertions
    chk_read_first_wait: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST)
        else $error("read did not wait in its first cycle");
    chk_read_answer: assert property (AVS_READ |-> ##[0:1] !AVS_WAITREQUEST)
        else $error("read not answered within one cycle");
    chk_write_no_wait: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
        else $error("write was made to wait");
    chk_ctrl_top_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0
        |-> AVS_READDATA[7] == 1'b0) else $error("control bit 7 read as one");
    chk_rdata_holds: assert property (!AVS_READ |=> $stable(AVS_READDATA))
        else $error("read data changed outside a read");
    chk_precharge_opposed: assert property (PRECHARGE_SENSOR_HIGH != PRECHARGE_HOLD_HIGH)
        else $error("precharge levels not opposed");
    chk_start_single: assert property (CONV_START |=> !CONV_START)
        else $error("conversion start held longer than one cycle");
    chk_reset_quiet: assert property ($fell(RST) |-> !IRQ && !CONV_START && PRECHARGE_SENSOR_HIGH)
        else $error("outputs not at rest after reset");
    cov_read: cover property (AVS_READ && !AVS_WAITREQUEST);
    cov_write: cover property (AVS_WRITE);
    cov_start: cover property (CONV_START);
    cov_double: cover property (PRECHARGE_HOLD_HIGH);
endmodule
bind aetu_core aetu_chk chk_u (.CLK_SYS(CLK_SYS), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .CONV_START(CONV_START),
    .PRECHARGE_HOLD_HIGH(PRECHARGE_HOLD_HIGH), .PRECHARGE_SENSOR_HIGH(PRECHARGE_SENSOR_HIGH),
    .IRQ(IRQ));
`default_nettype wire

// ### aetu_conv_model.sv
// Behavioural model of the conversion core facing the unit.
`timescale 1ns/1ps
`default_nettype none
module aetu_conv_model
#(
    parameter int LAT = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Conversion handshake
    input wire logic conv_start,
    output logic conv_done,
    output logic [aetu_pkg::RES_W-1:0] conv_result
);
    import aetu_pkg::*;
    int cnt_ff;
    logic [RES_W-1:0] smp_ff;
    // Result is only valid with the done pulse; it toggles otherwise.
    always_ff @(posedge clk)
    begin
        conv_done <= 1'b0;
        conv_result <= ~conv_result;
        if (rst)
        begin
            cnt_ff <= 0;
            smp_ff <= 16'h0100;
            conv_result <= 16'h5A5A;
        end
        else if (conv_start)
            cnt_ff <= LAT;
        else if (cnt_ff == 1)
        begin
            cnt_ff <= 0;
            conv_done <= 1'b1;
            conv_result <= smp_ff;
            smp_ff <= smp_ff + 16'h0123;
        end
        else if (cnt_ff > 1)
            cnt_ff <= cnt_ff - 1;
    end
endmodule
`default_nettype wire

// ### test_adc_error_threshold_unit.sv
// Register-level testbench of the ADC error and threshold unit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
    $display("MISMATCH %0t got %h expected %h", $time, got, exp); end end
module test_adc_error_threshold_unit;
    import aetu_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    wire logic [31:0] avs_readdata;
    wire logic avs_waitrequest;
    wire logic conv_start;
    wire logic conv_done;
    wire logic [RES_W-1:0] conv_result;
    int fails = 0;
    int total_checks = 0;
    logic [31:0] rd;
    wire logic irq;
    wire logic hold_high;
    wire logic sensor_high;
    logic saw_hold;
    aetu_core dut_u (.CLK_SYS(clk_sys), .RST(rst), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .CONV_START(conv_start), .CONV_DONE(conv_done), .CONV_RESULT(conv_result),
        .PRECHARGE_HOLD_HIGH(hold_high), .PRECHARGE_SENSOR_HIGH(sensor_high), .IRQ(irq));
    // Remembers whether the inverted precharge phase was ever seen.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            saw_hold <= 1'b0;
        end
        else if (hold_high && !sensor_high)
        begin
            saw_hold <= 1'b1;
        end
    end
    aetu_conv_model conv_u (.clk(clk_sys), .rst(rst), .conv_start(conv_start),
        .conv_done(conv_done), .conv_result(conv_result));
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ==========================================================
    // Bus tasks
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        begin
            n = 0;
            avs_address <= a;
            avs_writedata <= wd;
            avs_read <= !wr;
            avs_write <= wr;
            @(posedge clk_sys);
            while (avs_waitrequest !== 1'b0 && n < 50)
            begin
                @(posedge clk_sys);
                n++;
            end
            if (n == 50)
            begin
                fails++;
                $display("MISMATCH %0t bus request not answered", $time);
            end
            rd = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task automatic wait_done;
        int n;
        begin
            n = 0;
            xfer(1'b0, ADDR_STATUS, 32'h0);
            while (rd[ST_DONE_BIT] !== 1'b1 && n < 40)
            begin
                xfer(1'b0, ADDR_STATUS, 32'h0);
                n++;
            end
        end
    endtask
    task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
        begin
            xfer(1'b0, a, 32'h0);
            `CHK(rd, exp)
        end
    endtask
    task automatic run_check(input logic [7:0] ctl, input logic [3:0] mode,
        input logic [31:0] exp_err, input logic [31:0] exp_st, input logic exp_irq);
        begin
            xfer(1'b1, ADDR_CTRL, {24'h0, ctl});
            xfer(1'b1, ADDR_MODE, {28'h0, mode});
            wait_done();
            reg_check(ADDR_ERROR, exp_err);
            reg_check(ADDR_STATUS, exp_st);
            `CHK(irq, exp_irq)
            xfer(1'b1, ADDR_IRQ_CLR, 32'h3);
            `CHK(irq, 1'b0)
        end
    endtask
    task automatic wrap_up;
        begin
            $display("checks %0d mismatches %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial
    begin
        #200000;
        fails++;
        wrap_up();
    end
    // ==========================================================
    // Tests
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int a = 0; a < 11; a++)
            reg_check(4'(a), 32'h0);
        for (int i = 0; i < 128; i++)
        begin
            xfer(1'b1, ADDR_CTRL, {24'h0, 1'b1, 7'(i)});
            reg_check(ADDR_CTRL, {25'h0, 7'(i)});
        end
        xfer(1'b1, ADDR_UPPER, 32'h0000_0200);
        xfer(1'b1, ADDR_LOWER, 32'h0000_0050);
        xfer(1'b1, ADDR_SETPT, 32'h0000_0100);
        xfer(1'b1, ADDR_FILT, 32'h0000_0080);
        xfer(1'b1, ADDR_IRQ_EN, 32'h0000_0003);
        reg_check(ADDR_UPPER, 32'h0000_0200);
        reg_check(ADDR_LOWER, 32'h0000_0050);
        reg_check(ADDR_SETPT, 32'h0000_0100);
        reg_check(ADDR_FILT, 32'h0000_0080);
        reg_check(ADDR_IRQ_EN, 32'h0000_0003);
        run_check(8'h07, 4'h8, 32'h0000_0100, 32'h3, 1'b1);
        reg_check(ADDR_PREV, 32'h0);
        run_check(8'h1E, 4'h8, 32'h0000_0123, 32'h2, 1'b1);
        reg_check(ADDR_MODE, 32'h0);
        reg_check(ADDR_PREV, 32'h0000_0100);
        run_check(8'h22, 4'h8, 32'h0000_02C6, 32'h3, 1'b1);
        run_check(8'h44, 4'h8, 32'h0000_02C6, 32'h3, 1'b1);
        run_check(8'h51, 4'h8, 32'hFFFF_FF80, 32'h3, 1'b1);
        run_check(8'h37, 4'h8, 32'hFFFF_FF80, 32'h2, 1'b1);
        run_check(8'h03, 4'h8, 32'h0000_0123, 32'h3, 1'b1);
        run_check(8'h05, 4'h8, 32'h0000_0123, 32'h3, 1'b1);
        xfer(1'b1, ADDR_IRQ_EN, 32'h0000_0001);
        run_check(8'h00, 4'h8, 32'h0000_0123, 32'h2, 1'b0);
        xfer(1'b1, ADDR_IRQ_EN, 32'h0000_0003);
        run_check(8'h0D, 4'h9, 32'h0000_0123, 32'h3, 1'b1);
        reg_check(ADDR_MODE, 32'h1);
        xfer(1'b1, ADDR_CTRL, 32'h0000_000E);
        xfer(1'b1, ADDR_MODE, 32'h0000_0009);
        wait_done();
        xfer(1'b1, ADDR_IRQ_CLR, 32'h3);
        wait_done();
        reg_check(ADDR_MODE, 32'h9);
        reg_check(ADDR_ERROR, 32'h0000_0123);
        xfer(1'b1, ADDR_CTRL, 32'h0000_0007);
        xfer(1'b1, ADDR_IRQ_CLR, 32'h3);
        wait_done();
        reg_check(ADDR_STATUS, 32'h3);
        reg_check(ADDR_MODE, 32'h9);
        xfer(1'b1, ADDR_MODE, 32'h0000_0001);
        repeat (30) @(posedge clk_sys);
        xfer(1'b1, ADDR_IRQ_CLR, 32'h3);
        repeat (30) @(posedge clk_sys);
        reg_check(ADDR_STATUS, 32'h0);
        reg_check(ADDR_MODE, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        `CHK(saw_hold, 1'b0)
        reg_check(ADDR_CTRL, 32'h0);
        reg_check(ADDR_MODE, 32'h0);
        reg_check(ADDR_UPPER, 32'h0);
        xfer(1'b1, ADDR_FILT, 32'h0000_0080);
        xfer(1'b1, ADDR_IRQ_EN, 32'h0000_0003);
        run_check(8'h27, 4'hA, 32'h0000_00A3, 32'h3, 1'b1);
        `CHK(saw_hold, 1'b1)
        run_check(8'h00, 4'hA, 32'h0000_0123, 32'h2, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
